//--- hdl/crt_router.sv
// Purpose: Route processor-bus transactions to memory, PCI, ROM or registers
// Assumes: CPU drops a request after the edge that takes it while ready is high
// Notes: One transaction in flight; posted PCI writes hold cpu_ready low
// How it works
// - Addresses below 2G go to system memory with the address unchanged.
// - 2G to 2G+8M makes PCI I/O or register access, 8M or 64K target.
// - 2G+8M to 2G+16M makes type 0 configuration cycles.
// - 2G+16M to 3G-8M makes PCI I/O cycles at 16M upward.
// - 3G-8M to 3G is bridge registers; read of top-16 is intack.
// - 3G up to the ROM window makes PCI memory cycles from zero.
// - Top 2M is local ROM, or PCI memory near 1G when remote.
// - Empty memory reads all ones, writes drop, both set error bit 5.
// - Non-contiguous mode maps each 4K page to 32 ports, mirrored.
// - Map register and options register pick I/O mode; contiguous at reset.
// - Contiguous mode passes address bits 29 to 0 for I/O.
// - PCI addresses clear top two bits and unmunge in little-endian.
// - Low two PCI address bits are zero except for I/O cycles.
// - Memory writes are posted; bursts and in-8-byte singles accepted.
// - PCI accepts in-4-byte transfers and aligned 8-byte writes, no bursts.
// - After a PCI retry drop request and stay off two clocks.
// - PCI reads return data, or retry CPU on retry or snoop first.
// - PCI I/O writes are not posted; PCI retry retries the CPU.
// - PCI memory writes are posted and reissued until done.
// - 8-byte PCI write holds CPU for first half, posts second half.
// - Unclaimed PCI I/O cycles are master-aborted.
// - Address-only transfers never start PCI or memory cycles.
`timescale 1ns/10ps
module crt_router (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// Processor bus
	input wire logic cpu_valid_in,
	input wire crt_pkg::crt_cpu_req_type cpu_req_in,
	output logic cpu_ready_out,
	output logic cpu_ack_out,
	output logic cpu_retry_out,
	output logic cpu_err_out,
	output logic [63:0] cpu_rdata_out,
	// System memory
	input wire logic mem_present_in,
	input wire logic mem_ack_in,
	input wire logic [63:0] mem_rdata_in,
	output logic mem_req_out,
	output logic mem_write_out,
	output logic [31:0] mem_addr_out,
	output logic [63:0] mem_wdata_out,
	// PCI master
	input wire logic pci_gnt_n_in,
	input wire logic pci_bus_idle_in,
	input wire logic pci_done_in,
	input wire logic pci_retry_in,
	input wire logic pci_abort_in,
	input wire logic pci_snoop_in,
	input wire logic [31:0] pci_rdata_in,
	output logic pci_req_n_out,
	output logic pci_start_out,
	output crt_pkg::crt_pci_cmd_type pci_cmd_out,
	// Directly attached ROM
	input wire logic rom_direct_in,
	input wire logic rom_done_in,
	input wire logic [63:0] rom_rdata_in,
	output logic rom_req_out,
	output logic rom_write_out
);
	typedef enum logic [2:0] {ST_IDLE, ST_MEM_RD, ST_ROM, ST_REQ, ST_RUN,
		ST_BACKOFF} crt_state_type;
	crt_state_type state, next_state;
	logic [1:0] cnt, next_cnt;
	logic second, next_second;
	logic posted, next_posted;
	logic [31:0] hi, next_hi;
	logic [7:0] opts, map_sel, err_stat;
	logic next_ack, next_retry, next_err, next_mreq, next_mwr;
	logic next_start, next_rom, next_romwr, set_memsel, breg_we;
	logic [63:0] next_rdata, next_mwd;
	logic [31:0] next_maddr;
	crt_pkg::crt_pci_cmd_type next_cmd;
	crt_pkg::crt_target_type tgt;
	logic [31:0] xaddr;
	logic [3:0] xcmd;

	// Request fields and mode bits
	wire [31:0] addr = cpu_req_in.addr;
	wire [3:0] size = cpu_req_in.size;
	wire take = cpu_valid_in && cpu_ready_out;
	wire is_wr = cpu_req_in.kind == crt_pkg::KIND_WRITE;
	wire is_rd = cpu_req_in.kind == crt_pkg::KIND_READ;
	wire addr_only = cpu_req_in.kind == crt_pkg::KIND_ADDR_ONLY;
	wire le_mode = opts[crt_pkg::OPT_LE_BIT];
	wire noncontig = opts[crt_pkg::OPT_NONCONTIG_BIT] &&
		map_sel[crt_pkg::MAP_NONCONTIG_BIT];

	crt_addr_xlate u_xlate (
		.addr_in(addr),
		.size_in(size),
		.write_in(is_wr),
		.le_in(le_mode),
		.noncontig_in(noncontig),
		.rom_direct_in(rom_direct_in),
		.target_out(tgt),
		.pci_addr_out(xaddr),
		.pci_cmd_out(xcmd)
	);

	// Size and alignment checks per destination
	wire [4:0] end4 = {3'b000, addr[1:0]} + {1'b0, size};
	wire [4:0] end8 = {2'b00, addr[2:0]} + {1'b0, size};
	wire dbl = size == crt_pkg::SZ_D;
	wire dbl_ok = is_wr && addr[2:0] == 3'b000;
	wire pci_bad = cpu_req_in.burst ||
		(dbl ? !dbl_ok : end4 > crt_pkg::PCI_SPAN);
	wire mem_bad = !cpu_req_in.burst && end8 > crt_pkg::MEM_SPAN;
	wire is_pci = tgt == crt_pkg::TGT_PCI_IO || tgt == crt_pkg::TGT_CFG0 ||
		tgt == crt_pkg::TGT_INTACK || tgt == crt_pkg::TGT_PCI_MEM;
	wire post_now = is_wr && !dbl &&
		tgt == crt_pkg::TGT_PCI_MEM;

	// Bridge register read mux; unmapped indices read all ones
	wire [7:0] idx = addr[7:0];
	wire map_hit = addr == crt_pkg::IO_MAP_ADDR;
	wire idx_ok = map_hit || idx == crt_pkg::OPTS_IDX ||
		idx == crt_pkg::ERR_IDX;
	wire [7:0] breg_byte = map_hit ? map_sel :
		idx == crt_pkg::OPTS_IDX ? opts : err_stat;
	wire [63:0] breg_word = idx_ok ? {56'h0000_0000_0000_00, breg_byte} :
		'1;
	wire [7:0] wbyte = cpu_req_in.wdata[7:0];
	wire [7:0] memsel_mask = 8'h01 << crt_pkg::ERR_MEMSEL_BIT;

	// Transaction sequencer
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_second = second;
		next_posted = posted;
		next_hi = hi;
		next_cmd = pci_cmd_out;
		next_rdata = cpu_rdata_out;
		next_mwr = mem_write_out;
		next_maddr = mem_addr_out;
		next_mwd = mem_wdata_out;
		next_romwr = rom_write_out;
		next_ack = 1'b0;
		next_retry = 1'b0;
		next_err = 1'b0;
		next_mreq = 1'b0;
		next_start = 1'b0;
		next_rom = 1'b0;
		set_memsel = 1'b0;
		breg_we = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (take && addr_only) begin
					next_ack = 1'b1;
				end else if (take && tgt == crt_pkg::TGT_MEM) begin
					if (mem_bad) begin
						next_err = 1'b1;
					end else if (!mem_present_in) begin
						set_memsel = 1'b1;
						next_ack = 1'b1;
						if (is_rd) begin
							next_rdata = '1;
						end
					end else begin
						next_mreq = 1'b1;
						next_mwr = is_wr;
						next_maddr = addr;
						next_mwd = cpu_req_in.wdata;
						next_ack = is_wr;
						if (!is_wr) begin
							next_state = ST_MEM_RD;
						end
					end
				end else if (take && tgt == crt_pkg::TGT_BREG) begin
					next_ack = 1'b1;
					breg_we = is_wr;
					if (is_rd) begin
						next_rdata = breg_word;
					end
				end else if (take && tgt == crt_pkg::TGT_ROM) begin
					next_rom = 1'b1;
					next_romwr = is_wr;
					next_cmd.addr = xaddr;
					next_cmd.data = cpu_req_in.wdata[31:0];
					next_state = ST_ROM;
				end else if (take && is_pci) begin
					if (pci_bad) begin
						next_err = 1'b1;
					end else if (pci_snoop_in) begin
						next_retry = 1'b1;
					end else begin
						next_cmd.cmd = xcmd;
						next_cmd.addr = xaddr;
						next_cmd.data = dbl ? cpu_req_in.wdata[63:32] :
							cpu_req_in.wdata[31:0];
						next_hi = cpu_req_in.wdata[31:0];
						next_second = dbl;
						next_posted = post_now;
						next_ack = post_now;
						next_state = ST_REQ;
					end
				end
			end
			ST_MEM_RD: begin
				if (mem_ack_in) begin
					next_ack = 1'b1;
					next_rdata = mem_rdata_in;
					next_state = ST_IDLE;
				end
			end
			ST_ROM: begin
				if (rom_done_in) begin
					next_ack = 1'b1;
					next_rdata = rom_rdata_in;
					next_state = ST_IDLE;
				end
			end
			ST_REQ: begin
				if (!posted && pci_snoop_in) begin
					next_retry = 1'b1;
					next_second = 1'b0;
					next_state = ST_IDLE;
				end else if (!pci_gnt_n_in && pci_bus_idle_in) begin
					next_start = 1'b1;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (pci_done_in || pci_abort_in) begin
					if (second) begin
						next_ack = 1'b1;
						next_cmd.addr = pci_cmd_out.addr + crt_pkg::HALF_OFS;
						next_cmd.data = hi;
						next_second = 1'b0;
						next_posted = 1'b1;
						next_state = ST_REQ;
					end else begin
						next_ack = !posted;
						// Master abort completes with all ones
						next_rdata = pci_abort_in ? '1 :
							{32'h0000_0000, pci_rdata_in};
						next_posted = 1'b0;
						next_state = ST_IDLE;
					end
				end else if (pci_retry_in) begin
					next_cnt = crt_pkg::BACKOFF_CYCLES;
					next_state = ST_BACKOFF;
					if (!posted) begin
						next_retry = 1'b1;
						next_second = 1'b0;
					end
				end
			end
			ST_BACKOFF: begin
				next_cnt = cnt - 2'h1;
				if (cnt == 2'h1) begin
					// Posted work is reissued, else the CPU retries
					next_state = posted ? ST_REQ : ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			cnt <= 2'h0;
			second <= 1'b0;
			posted <= 1'b0;
			hi <= 32'h0000_0000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			second <= next_second;
			posted <= next_posted;
			hi <= next_hi;
		end
	end

	// Registered outputs; request drops outside the request state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cpu_ready_out <= 1'b0;
			cpu_ack_out <= 1'b0;
			cpu_retry_out <= 1'b0;
			cpu_err_out <= 1'b0;
			cpu_rdata_out <= 64'h0000_0000_0000_0000;
			mem_req_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_addr_out <= 32'h0000_0000;
			mem_wdata_out <= 64'h0000_0000_0000_0000;
			pci_req_n_out <= 1'b1;
			pci_start_out <= 1'b0;
			pci_cmd_out <= '0;
			rom_req_out <= 1'b0;
			rom_write_out <= 1'b0;
		end else begin
			cpu_ready_out <= next_state == ST_IDLE;
			cpu_ack_out <= next_ack;
			cpu_retry_out <= next_retry;
			cpu_err_out <= next_err;
			cpu_rdata_out <= next_rdata;
			mem_req_out <= next_mreq;
			mem_write_out <= next_mwr;
			mem_addr_out <= next_maddr;
			mem_wdata_out <= next_mwd;
			pci_req_n_out <= next_state != ST_REQ;
			pci_start_out <= next_start;
			pci_cmd_out <= next_cmd;
			rom_req_out <= next_rom;
			rom_write_out <= next_romwr;
		end
	end

	// Mode and error registers; a new error beats a clear
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			opts <= crt_pkg::OPTS_RST;
			map_sel <= crt_pkg::MAP_RST;
			err_stat <= crt_pkg::ERR_RST;
		end else begin
			if (breg_we && map_hit) begin
				map_sel <= wbyte;
			end
			if (breg_we && !map_hit && idx == crt_pkg::OPTS_IDX) begin
				opts <= wbyte;
			end
			err_stat <= (err_stat & ~((breg_we && !map_hit &&
				idx == crt_pkg::ERR_IDX) ? wbyte : 8'h00)) |
				(set_memsel ? memsel_mask : 8'h00);
		end
	end

	// Checks on routing and PCI sequencing
	a_addr_only_quiet: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && addr_only |=>
		cpu_ack_out && !mem_req_out && !rom_req_out ##1 !pci_start_out)
		else $error("address-only transfer started a cycle");
	a_mem_pass_addr: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && !addr_only && tgt ==
		crt_pkg::TGT_MEM && !mem_bad && mem_present_in |=>
		mem_req_out && mem_addr_out == $past(addr))
		else $error("memory address not passed unchanged");
	a_unpop_ones: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && is_rd && tgt == crt_pkg::TGT_MEM &&
		!mem_bad && !mem_present_in |=> cpu_ack_out &&
		cpu_rdata_out == '1 && err_stat[crt_pkg::ERR_MEMSEL_BIT])
		else $error("empty memory read not all ones with flag");
	a_retry_backoff: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) state == ST_RUN && pci_retry_in &&
		!pci_done_in && !pci_abort_in |=> pci_req_n_out[*2] ##1
		(!pci_req_n_out || state == ST_IDLE))
		else $error("retry backoff not two clocks");
	a_pci_top_zero: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) pci_start_out |->
		pci_cmd_out.addr[31:30] == 2'b00)
		else $error("PCI address top bits not zero");
	a_low_bits_zero: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) pci_start_out &&
		pci_cmd_out.cmd != crt_pkg::CMD_IO_RD &&
		pci_cmd_out.cmd != crt_pkg::CMD_IO_WR |->
		pci_cmd_out.addr[1:0] == 2'b00)
		else $error("low PCI address bits not zero");
	a_io_not_posted: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && is_wr && tgt ==
		crt_pkg::TGT_PCI_IO && !pci_bad && !pci_snoop_in |=>
		!cpu_ack_out && state == ST_REQ)
		else $error("I/O write was posted");
	a_mem_write_post: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && post_now && !pci_bad &&
		!pci_snoop_in |=> cpu_ack_out && posted)
		else $error("PCI memory write not posted");
	a_pci_burst_err: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) take && !addr_only && is_pci &&
		cpu_req_in.burst |=> cpu_err_out && state == ST_IDLE)
		else $error("burst toward PCI not refused");
	a_half_reissue: assert property (@(posedge core_clk_in)
		disable iff (!rst_n_in) state == ST_RUN && second && pci_done_in
		|=> cpu_ack_out && state == ST_REQ &&
		pci_cmd_out.addr == $past(pci_cmd_out.addr) + crt_pkg::HALF_OFS)
		else $error("second half not posted at next word");
endmodule

//--- hdl/crt_pkg.sv
// Purpose: Shared constants and types for the processor-bus address router
// Assumes: One clock; all ports synchronous to it
// Notes: PCI command codes follow the published PCI encoding
package crt_pkg;
	// Address region tags, top address bits
	localparam logic [8:0] IO_LO_TAG = 9'h100;
	localparam logic [8:0] CFG0_TAG = 9'h101;
	localparam logic [8:0] BREG_TAG = 9'h17F;
	localparam logic [10:0] ROM_TAG = 11'h7FF;
	localparam logic [31:0] IO_MAP_ADDR = 32'h8000_0850;
	localparam logic [31:0] INTACK_ADDR = 32'hBFFF_FFF0;
	localparam logic [31:0] HALF_OFS = 32'h0000_0004;
	// Indexed bridge registers
	localparam logic [7:0] OPTS_IDX = 8'hBA;
	localparam logic [7:0] ERR_IDX = 8'hC1;
	localparam int ERR_MEMSEL_BIT = 5;
	localparam int OPT_NONCONTIG_BIT = 0;
	localparam int OPT_LE_BIT = 5;
	localparam int MAP_NONCONTIG_BIT = 0;
	localparam logic [7:0] OPTS_RST = 8'h00;
	localparam logic [7:0] MAP_RST = 8'h00;
	localparam logic [7:0] ERR_RST = 8'h00;
	// Transfer sizes in bytes and boundaries
	localparam logic [3:0] SZ_B = 4'h1;
	localparam logic [3:0] SZ_H = 4'h2;
	localparam logic [3:0] SZ_W = 4'h4;
	localparam logic [3:0] SZ_D = 4'h8;
	localparam logic [4:0] PCI_SPAN = 5'h04;
	localparam logic [4:0] MEM_SPAN = 5'h08;
	// Unmunge masks for byte, halfword, word
	localparam logic [2:0] MUNGE_B = 3'h7;
	localparam logic [2:0] MUNGE_H = 3'h6;
	localparam logic [2:0] MUNGE_W = 3'h4;
	// Bus idle time after a retry, in clocks
	localparam logic [1:0] BACKOFF_CYCLES = 2'h2;
	// PCI commands
	localparam logic [3:0] CMD_INTACK = 4'h0;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;

	typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_ADDR_ONLY}
		crt_kind_type;
	typedef enum logic [2:0] {TGT_MEM, TGT_PCI_IO, TGT_CFG0, TGT_BREG,
		TGT_INTACK, TGT_PCI_MEM, TGT_ROM} crt_target_type;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] size;
		logic burst;
		crt_kind_type kind;
		logic [63:0] wdata;
	} crt_cpu_req_type;
	typedef struct packed {
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [31:0] data;
	} crt_pci_cmd_type;
endpackage

//--- hdl/crt_addr_xlate.sv
// Purpose: Target decode and PCI address formation for one CPU address
// Assumes: Purely combinational; caller registers the results
// Notes: Memory addresses are not touched here
`timescale 1ns/10ps
module crt_addr_xlate (
	// Request
	input wire logic [31:0] addr_in,
	input wire logic [3:0] size_in,
	input wire logic write_in,
	// Modes
	input wire logic le_in,
	input wire logic noncontig_in,
	input wire logic rom_direct_in,
	// Result
	output crt_pkg::crt_target_type target_out,
	output logic [31:0] pci_addr_out,
	output logic [3:0] pci_cmd_out
);
	// Region decode from the top address bits
	wire in_io_lo = addr_in[31:23] == crt_pkg::IO_LO_TAG;
	wire in_cfg0 = addr_in[31:23] == crt_pkg::CFG0_TAG;
	wire in_breg = addr_in[31:23] == crt_pkg::BREG_TAG;
	wire in_rom = addr_in[31:21] == crt_pkg::ROM_TAG;
	wire map_hit = addr_in == crt_pkg::IO_MAP_ADDR;
	wire intack = addr_in == crt_pkg::INTACK_ADDR && !write_in;
	wire is_io = (in_io_lo && !map_hit) ||
		(addr_in[31:30] == 2'b10 && !in_io_lo && !in_cfg0 && !in_breg);
	assign target_out = !addr_in[31] ? crt_pkg::TGT_MEM :
		map_hit ? crt_pkg::TGT_BREG :
		is_io ? crt_pkg::TGT_PCI_IO :
		in_cfg0 ? crt_pkg::TGT_CFG0 :
		intack ? crt_pkg::TGT_INTACK :
		in_breg ? crt_pkg::TGT_BREG :
		(in_rom && rom_direct_in) ? crt_pkg::TGT_ROM :
		crt_pkg::TGT_PCI_MEM;

	// Base address: noncontig squeezes each 4K page to 32 ports
	wire [31:0] base = (noncontig_in && in_io_lo) ?
		{16'h0000, addr_in[22:12], addr_in[4:0]} :
		(in_rom && rom_direct_in) ? {11'h000, addr_in[20:0]} :
		{2'b00, addr_in[29:0]};
	// Little-endian unmunge; 8-byte and odd sizes pass unchanged
	wire [2:0] mask = !le_in ? 3'h0 :
		size_in == crt_pkg::SZ_B ? crt_pkg::MUNGE_B :
		size_in == crt_pkg::SZ_H ? crt_pkg::MUNGE_H :
		size_in == crt_pkg::SZ_W ? crt_pkg::MUNGE_W : 3'h0;
	wire [2:0] low = base[2:0] ^ mask;
	assign pci_addr_out = {base[31:3], low[2],
		is_io ? low[1:0] : 2'b00};

	// Command selection
	assign pci_cmd_out = is_io ?
		(write_in ? crt_pkg::CMD_IO_WR : crt_pkg::CMD_IO_RD) :
		in_cfg0 ? (write_in ? crt_pkg::CMD_CFG_WR : crt_pkg::CMD_CFG_RD) :
		intack ? crt_pkg::CMD_INTACK :
		(write_in ? crt_pkg::CMD_MEM_WR : crt_pkg::CMD_MEM_RD);
endmodule

//--- verif/crt_far_model.sv
// Purpose: Far-side model of system memory and PCI targets
// Assumes: One clock; ack, done, retry and abort answers are one-cycle pulses
// Notes: Data lines show an inverse pattern when not qualified
`timescale 1ns/10ps
module crt_far_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Requests from the router
	input wire logic mem_req_in,
	input wire logic pci_req_n_in,
	input wire logic pci_start_in,
	// Bench control: 0 done, 1 retry, 2 master abort
	input wire logic [1:0] fail_in,
	// Answers
	output logic mem_ack_out,
	output logic [63:0] mem_rdata_out,
	output logic pci_gnt_n_out,
	output logic pci_idle_out,
	output logic pci_done_out,
	output logic pci_retry_out,
	output logic pci_abort_out,
	output logic [31:0] pci_rdata_out
);
	logic busy;
	logic slow;
	logic [1:0] wait_cnt;
	// Stale data never looks valid to a careless sampler
	assign mem_rdata_out = mem_ack_out ? 64'h0123_4567_89AB_CDEF :
		64'hFEDC_BA98_7654_3210;
	assign pci_rdata_out = pci_done_out ? 32'hC0DE_1234 : 32'h3F21_EDCB;
	assign pci_idle_out = !busy;
	// Grant a clock late; target waits 1 or 3 clocks in turn
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pci_gnt_n_out <= 1'b1;
			mem_ack_out <= 1'b0;
			pci_done_out <= 1'b0;
			pci_retry_out <= 1'b0;
			pci_abort_out <= 1'b0;
			busy <= 1'b0;
			slow <= 1'b0;
			wait_cnt <= 2'h0;
		end else begin
			pci_gnt_n_out <= pci_req_n_in;
			mem_ack_out <= mem_req_in;
			pci_done_out <= 1'b0;
			pci_retry_out <= 1'b0;
			pci_abort_out <= 1'b0;
			if (pci_start_in) begin
				busy <= 1'b1;
				slow <= !slow;
				wait_cnt <= slow ? 2'h3 : 2'h1;
			end else if (busy && wait_cnt != 2'h0) begin
				wait_cnt <= wait_cnt - 2'h1;
			end else if (busy) begin
				busy <= 1'b0;
				pci_done_out <= (fail_in == 2'h0);
				pci_retry_out <= (fail_in == 2'h1);
				pci_abort_out <= (fail_in == 2'h2);
			end
		end
	end
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the address router
// Assumes: Far-side model answers memory and PCI; ROM is remote
// Notes: Driver queues expected answers; a watcher pops and compares
`timescale 1ns/10ps
module testbench;
	localparam logic [63:0] PD = 64'h0000_0000_C0DE_1234;
	localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [2:0] ACK = 3'h1;
	localparam logic [2:0] RTY = 3'h2;
	localparam logic [2:0] ERR = 3'h4;
	localparam logic [31:0] CA[7] = '{32'h8000_0123, 32'h8080_0800,
		32'h8100_0011, 32'hBFFF_FFF0, 32'hC000_0106, 32'hFFDF_FFFC,
		32'hFFE0_0010};
	localparam logic [31:0] PA[7] = '{32'h0000_0123, 32'h0080_0800,
		32'h0100_0011, 32'h3FFF_FFF0, 32'h0000_0104, 32'h3FDF_FFFC,
		32'h3FE0_0010};
	localparam logic [3:0] SZ[7] = '{4'h1, 4'h4, 4'h1, 4'h4, 4'h2, 4'h4,
		4'h4};
	localparam logic [3:0] CM[7] = '{crt_pkg::CMD_IO_RD,
		crt_pkg::CMD_CFG_RD, crt_pkg::CMD_IO_RD, crt_pkg::CMD_INTACK,
		crt_pkg::CMD_MEM_RD, crt_pkg::CMD_MEM_RD, crt_pkg::CMD_MEM_RD};
	localparam logic [31:0] RA[5] = '{32'h8100_0000, 32'h8100_0002,
		32'h8100_0008, 32'h8100_0004, 32'h0000_0006};
	localparam logic [3:0] RS[5] = '{4'h4, 4'h4, 4'h8, 4'h8, 4'h4};
	localparam logic [3:0] LS[3] = '{4'h1, 4'h2, 4'h4};
	localparam logic [31:0] LX[3] = '{32'h0000_0007, 32'h0000_0006,
		32'h0000_0004};
	localparam crt_pkg::crt_kind_type RD = crt_pkg::KIND_READ;
	localparam crt_pkg::crt_kind_type WR = crt_pkg::KIND_WRITE;
	logic core_clk_in;
	logic rst_n_in;
	logic cpu_valid_in;
	crt_pkg::crt_cpu_req_type cpu_req_in;
	logic mem_present_in;
	logic pci_snoop_in;
	logic bst;
	logic [1:0] fail;
	logic [67:0] e;
	logic [68:0] p;
	logic [31:0] m;
	logic [31:0] r;
	logic [63:0] d;
	logic [67:0] aq[$];
	logic [68:0] pq[$];
	logic [31:0] mq[$];
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	integer seed = 32'ha34e;
	wire logic cpu_ready_out, cpu_ack_out, cpu_retry_out, cpu_err_out;
	wire logic mem_ack_in, mem_req_out, pci_gnt_n_in, pci_bus_idle_in;
	wire logic pci_done_in, pci_retry_in, pci_abort_in, pci_req_n_out;
	wire logic pci_start_out;
	wire logic [63:0] cpu_rdata_out, mem_rdata_in;
	wire logic [31:0] mem_addr_out, pci_rdata_in;
	wire crt_pkg::crt_pci_cmd_type pci_cmd_out;
	// Router under test; ROM kept remote, so its port is idle
	crt_router dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.cpu_valid_in(cpu_valid_in), .cpu_req_in(cpu_req_in),
		.cpu_ready_out(cpu_ready_out), .cpu_ack_out(cpu_ack_out),
		.cpu_retry_out(cpu_retry_out), .cpu_err_out(cpu_err_out),
		.cpu_rdata_out(cpu_rdata_out), .mem_present_in(mem_present_in),
		.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in),
		.mem_req_out(mem_req_out), .mem_write_out(),
		.mem_addr_out(mem_addr_out), .mem_wdata_out(),
		.pci_gnt_n_in(pci_gnt_n_in), .pci_bus_idle_in(pci_bus_idle_in),
		.pci_done_in(pci_done_in), .pci_retry_in(pci_retry_in),
		.pci_abort_in(pci_abort_in), .pci_snoop_in(pci_snoop_in),
		.pci_rdata_in(pci_rdata_in), .pci_req_n_out(pci_req_n_out),
		.pci_start_out(pci_start_out), .pci_cmd_out(pci_cmd_out),
		.rom_direct_in(1'b0), .rom_done_in(1'b0),
		.rom_rdata_in(64'h0000_0000_0000_0000), .rom_req_out(),
		.rom_write_out());
	crt_far_model far_u (.clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.mem_req_in(mem_req_out), .pci_req_n_in(pci_req_n_out),
		.pci_start_in(pci_start_out), .fail_in(fail),
		.mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in),
		.pci_gnt_n_out(pci_gnt_n_in), .pci_idle_out(pci_bus_idle_in),
		.pci_done_out(pci_done_in), .pci_retry_out(pci_retry_in),
		.pci_abort_out(pci_abort_in), .pci_rdata_out(pci_rdata_in));
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Expected PCI cycle; bit 32 of dd asks for a data compare
	task automatic pe(input logic [3:0] c, input logic [31:0] a,
		input logic [32:0] dd);
		pq.push_back({c, a, dd});
	endtask
	// One request, held through the taking edge
	task automatic run(input logic [31:0] a, input logic [3:0] s,
		input crt_pkg::crt_kind_type k, input logic [2:0] rs,
		input logic [63:0] dv);
		aq.push_back({k == RD, rs, dv});
		@(posedge core_clk_in);
		#1;
		while (cpu_ready_out !== 1'b1) begin
			@(posedge core_clk_in);
			#1;
		end
		cpu_req_in = '{addr: a, size: s, burst: bst, kind: k, wdata: dv};
		cpu_valid_in = 1'b1;
		@(posedge core_clk_in);
		#1;
		cpu_valid_in = 1'b0;
	endtask
	task automatic idle(input string nm);
		while (aq.size() + pq.size() + mq.size() != 0 ||
			cpu_ready_out !== 1'b1)
			@(posedge core_clk_in);
		$display("test %s finished", nm);
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	// Hang guard
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("[FAIL] run expected finish seen timeout");
			test_done();
		end
	end
	// Pulses last one cycle, so look mid-cycle once settled
	always @(negedge core_clk_in) begin
		if (rst_n_in && (cpu_ack_out | cpu_retry_out | cpu_err_out)) begin
			e = aq.size() != 0 ? aq.pop_front() : {4'hF, ONES};
			chk("answer", {cpu_err_out, cpu_retry_out, cpu_ack_out},
				e[66:64]);
			if (e[67] && cpu_ack_out) chk("rdata", cpu_rdata_out, e[63:0]);
		end
		if (rst_n_in && pci_start_out) begin
			p = pq.size() != 0 ? pq.pop_front() : {5'h1F, ONES};
			chk("pci_cmd", {pci_cmd_out.cmd, pci_cmd_out.addr}, p[68:33]);
			if (p[32]) chk("pci_data", pci_cmd_out.data, p[31:0]);
		end
		if (rst_n_in && mem_req_out) begin
			m = mq.size() != 0 ? mq.pop_front() : 32'hFFFF_FFFF;
			chk("mem_addr", mem_addr_out, m);
		end
	end
	// Request must stay off for two clocks after a retry
	always @(negedge core_clk_in) begin
		if (pci_retry_in === 1'b1) begin
			repeat (2) begin
				@(negedge core_clk_in);
				chk("backoff", pci_req_n_out, 1'b1);
			end
		end
	end
	initial begin
		rst_n_in = 1'b0;
		cpu_valid_in = 1'b0;
		cpu_req_in = '0;
		mem_present_in = 1'b1;
		pci_snoop_in = 1'b0;
		bst = 1'b0;
		fail = 2'h0;
		repeat (3) @(posedge core_clk_in);
		#1;
		rst_n_in = 1'b1;
		// Reset values, memory, empty memory
		run(32'hBF80_00BA, 4'h1, RD, ACK, 64'h0);
		run(32'h8000_0850, 4'h1, RD, ACK, 64'h0);
		mq.push_back(32'h0000_1234);
		run(32'h0000_1234, 4'h2, WR, ACK, 64'h5555);
		mq.push_back(32'h7FFF_FFF8);
		run(32'h7FFF_FFF8, 4'h8, RD, ACK,
			64'h0123_4567_89AB_CDEF);
		idle("memory");
		mem_present_in = 1'b0;
		run(32'h0000_4000, 4'h8, RD, ACK, ONES);
		run(32'h0000_4000, 4'h4, WR, ACK, 64'h1);
		idle("empty");
		mem_present_in = 1'b1;
		run(32'hBF80_00C1, 4'h1, RD, ACK, 64'h20);
		run(32'hBF80_00C1, 4'h1, WR, ACK, 64'h20);
		run(32'hBF80_00C1, 4'h1, RD, ACK, 64'h0);
		// One read into every PCI-bound window
		for (int i = 0; i < 7; i++) begin
			pe(CM[i], PA[i], 33'h0);
			run(CA[i], SZ[i], RD, ACK, PD);
		end
		idle("decode");
		// Posted writes above 3G, never cached
		for (int i = 0; i < 6; i++) begin
			r = ({$random(seed)} % 32'h3FE0_0000) & 32'hFFFF_FFFC;
			d = {32'h0, $random(seed)};
			pe(crt_pkg::CMD_MEM_WR, r, {1'b1, d[31:0]});
			run(32'hC000_0000 + r, 4'h4, WR, ACK, d);
		end
		idle("posted");
		// Non-contiguous ports, mirrors, then little-endian unmunge
		run(32'hBF80_00BA, 4'h1, WR, ACK, 64'h1);
		run(32'h8000_0850, 4'h1, WR, ACK, 64'h1);
		for (int i = 0; i < 2; i++) begin
			pe(crt_pkg::CMD_IO_RD, 32'h0000_0023, 33'h0);
			run(32'h8000_1003 + i * 32'h0FE0, 4'h1, RD, ACK,
				PD);
		end
		run(32'hBF80_00BA, 4'h1, WR, ACK, 64'h20);
		for (int i = 0; i < 3; i++) begin
			pe(crt_pkg::CMD_IO_RD, 32'h0100_0010 ^ LX[i], 33'h0);
			run(32'h8100_0010, LS[i], RD, ACK, PD);
		end
		run(32'hBF80_00BA, 4'h1, WR, ACK, 64'h0);
		idle("modes");
		// Refused shapes, then address-only transfers
		for (int i = 0; i < 5; i++) begin
			bst = (i == 0);
			run(RA[i], RS[i], i < 3 ? RD : WR, ERR, 64'h0);
		end
		bst = 1'b0;
		run(32'h8100_0000, 4'h4, crt_pkg::KIND_ADDR_ONLY, ACK, 64'h0);
		run(32'h0000_1000, 4'h8, crt_pkg::KIND_ADDR_ONLY, ACK, 64'h0);
		pe(crt_pkg::CMD_IO_WR, 32'h0100_0008, 33'h1_1111_2222);
		pe(crt_pkg::CMD_IO_WR, 32'h0100_000C, 33'h1_3333_4444);
		run(32'h8100_0008, 4'h8, WR, ACK,
			64'h1111_2222_3333_4444);
		idle("refuse");
		// Retry, reissue, abort and snoop
		fail = 2'h1;
		pe(crt_pkg::CMD_IO_RD, 32'h0100_0020, 33'h0);
		run(32'h8100_0020, 4'h4, RD, RTY, 64'h0);
		pe(crt_pkg::CMD_IO_WR, 32'h0100_0024, 33'h1_0000_0099);
		run(32'h8100_0024, 4'h4, WR, RTY, 64'h99);
		pe(crt_pkg::CMD_MEM_WR, 32'h0000_0040, 33'h1_0000_0077);
		pe(crt_pkg::CMD_MEM_WR, 32'h0000_0040, 33'h1_0000_0077);
		run(32'hC000_0040, 4'h4, WR, ACK, 64'h77);
		while (pci_retry_in !== 1'b1)
			@(posedge core_clk_in);
		#1;
		fail = 2'h0;
		idle("retry");
		fail = 2'h2;
		pe(crt_pkg::CMD_IO_RD, 32'h0100_0030, 33'h0);
		run(32'h8100_0030, 4'h4, RD, ACK, ONES);
		idle("abort");
		fail = 2'h0;
		pci_snoop_in = 1'b1;
		run(32'h8100_0030, 4'h4, RD, RTY, 64'h0);
		idle("snoop");
		pci_snoop_in = 1'b0;
		test_done();
	end
endmodule
